/* bench/mld_core_props.sv */
// checker of the dimmer control ports: shutdown, alert, open bypass, defaults
// assumes one clk/rstn domain; bound to every mld_core below
`timescale 1ns/1ns
`include "mld_map.vh"
module mld_core_props #(
    parameter VARIANT_ONE = 0
) (
    input wire clk,
    input wire rstn,
    input wire scl_in,
    input wire sda_out,
    input wire sda_oe,
    input wire alert_oe,
    input wire enable_undervoltage_in,
    input wire [7:0] open_detect_in,
    input wire [7:0] short_detect_in,
    input wire overheat_in,
    input wire [7:0] switch_on,
    input wire [15:0] open_threshold_sel,
    input wire [1:0] short_threshold_sel,
    input wire shutdown_out
);
    localparam [1:0] OTH_DEF = VARIANT_ONE ? `MLD_OTH_RST1 : `MLD_OTH_RST0;
    localparam [7:0] SW_DEF = VARIANT_ONE ? ~`MLD_ACM_RST1 : ~`MLD_ACM_RST0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // cycles since any fault input was last high, saturating
    logic [3:0] fault_age_q;
    wire fault_now = (|open_detect_in) || (|short_detect_in) || overheat_in;
    always @(posedge clk) begin
        if (fault_now)
            fault_age_q <= 4'h0;
        else if (!rstn)
            fault_age_q <= 4'hf;
        else if (fault_age_q != 4'hf)
            fault_age_q <= fault_age_q + 4'h1;
    end
    // ****************************************
    // sequences
    // ****************************************
    sequence en_steady;
        ($stable(enable_undervoltage_in))[*5];
    endsequence
    sequence open_held;
        (!shutdown_out && open_detect_in != 8'h00 && $stable(open_detect_in))[*6];
    endsequence
    // ****************************************
    // properties
    // ****************************************
    sda_open_drain_a: assert property (sda_oe |-> !sda_out)
        else $error("data pin driven high");
    shut_tracks_en_a: assert property (en_steady |-> shutdown_out == !enable_undervoltage_in)
        else $error("shutdown does not follow enable");
    shut_switch_off_a: assert property (shutdown_out [*3] |-> switch_on == 8'h00)
        else $error("switch on in shutdown");
    alert_needs_en_a: assert property ((shutdown_out || $past(shutdown_out)) |-> !alert_oe)
        else $error("alert asserted in shutdown");
    alert_cause_a: assert property ($rose(alert_oe) |-> fault_age_q < 4'h8)
        else $error("alert without a fault");
    open_bypass_a: assert property (open_held |-> (switch_on & open_detect_in) == open_detect_in)
        else $error("open channel not bypassed");
    ack_on_low_a: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 2))
        else $error("data drive changed while clock high");
    thr_default_a: assert property ($fell(shutdown_out) |-> ##[0:2]
        (open_threshold_sel == {8{OTH_DEF}} && short_threshold_sel == `MLD_STH_RST))
        else $error("thresholds not at default after enable");
    sw_default_a: assert property ($fell(shutdown_out) && open_detect_in == 8'h00 |-> ##[1:3] switch_on == SW_DEF)
        else $error("switches not at default after enable");
endmodule

bind mld_core mld_core_props #(.VARIANT_ONE(VARIANT_ONE)) u_props (.clk(clk), .rstn(rstn), .scl_in(scl_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .alert_oe(alert_oe), .enable_undervoltage_in(enable_undervoltage_in),
    .open_detect_in(open_detect_in), .short_detect_in(short_detect_in), .overheat_in(overheat_in),
    .switch_on(switch_on), .open_threshold_sel(open_threshold_sel), .short_threshold_sel(short_threshold_sel),
    .shutdown_out(shutdown_out));

/* bench/mld_i2c_master.sv */
// serial bus master model: start, stop, one byte with its acknowledge bit
// assumes the bench resolves the open-drain data line with a pull-up
`timescale 1ns/1ns
module mld_i2c_master (
    input wire clk,
    input wire sda_bus,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // ****************************************
    // bus phases
    // ****************************************
    // data moves mid low phase so the slave never sees it beside a clock edge
    task automatic start();
        sda_low = 1'b1;
        tick(20);
        scl = 1'b0;
        tick(10);
    endtask
    task automatic stop();
        sda_low = 1'b1;
        tick(10);
        scl = 1'b1;
        tick(20);
        sda_low = 1'b0;
        tick(20);
    endtask
    task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= -1; i--) begin
            sda_low = (i < 0) ? mack : !tx[i];
            tick(10);
            scl = 1'b1;
            tick(20);
            if (i >= 0)
                rx[i] = sda_bus;
            else
                ack = !sda_bus;
            scl = 1'b0;
            tick(10);
        end
    endtask
endmodule

/* bench/tb.sv */
// self-checking bench of the dimmer control: rows, shutdown, faults, alert, pwm period
// assumes mld_core, its bound checker and the bus master model are compiled first
`timescale 1ns/1ns
module tb;
    typedef struct packed {
        logic [7:0] adr;
        logic [7:0] d0;
        logic [7:0] d1;
        logic [7:0] sw;
        logic [15:0] oth;
        logic [1:0] sth;
    } mld_row_t;
    logic clk, rstn, en, ext, oh, scl, m_low, ack;
    logic [3:0] sel;
    logic [7:0] od, sd, rx;
    logic [7:0] rb [4];
    wire sda_oe, alert_oe, shut;
    wire sda_o, alert_o;
    wire [7:0] sw;
    wire [15:0] oth;
    wire [1:0] sth;
    wire sda = !(sda_oe || m_low);
    int n_fail = 0;
    int checks_done = 0;
    time t0, t1, t2;
    mld_row_t rows [5] = '{
        '{8'h5e, 8'h0f, 8'h02, 8'hf0, 16'hffff, 2'h2},
        '{8'h5e, 8'ha5, 8'h03, 8'h5a, 16'hffff, 2'h3},
        '{8'hbe, 8'h40, 8'h00, 8'h5e, 16'hffcf, 2'h3},
        '{8'hbe, 8'h28, 8'h00, 8'h5c, 16'hffc3, 2'h3},
        '{8'h5e, 8'hff, 8'h00, 8'h00, 16'hffc3, 2'h0}
    };
    mld_core #(.VARIANT_ONE(0)) uut (.clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(sda_o),
        .sda_oe(sda_oe), .alert_out(alert_o), .alert_oe(alert_oe), .addr_sel_in(sel), .enable_undervoltage_in(en),
        .pwm_clock_pin(ext), .open_detect_in(od), .short_detect_in(sd), .overheat_in(oh), .switch_on(sw),
        .open_threshold_sel(oth), .short_threshold_sel(sth), .shutdown_out(shut));
    mld_i2c_master u_mst (.clk(clk), .sda_bus(sda), .scl(scl), .sda_low(m_low));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // external dimming clock runs free, period eight clk cycles, each edge 2 ns ahead of a clk rise
    initial begin
        ext = 1'b0;
        #13;
        forever #40 ext = ~ext;
    end
    // ****************************************
    // checks and bus cycles
    // ****************************************
    task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_t(input time got, input time exp);
        checks_done++;
        if (got > exp + 20 || got + 20 < exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1, input logic eack);
        u_mst.start();
        u_mst.xfer(a, 1'b0, rx, ack);
        chk_v(ack, eack);
        u_mst.xfer(d0, 1'b0, rx, ack);
        u_mst.xfer(d1, 1'b0, rx, ack);
        u_mst.stop();
    endtask
    task automatic rd(input logic [7:0] a, input int n);
        u_mst.start();
        u_mst.xfer(a, 1'b0, rx, ack);
        chk_v(ack, 1'b1);
        for (int i = 0; i < n; i++)
            u_mst.xfer(8'hff, i < n - 1, rb[i], ack);
        u_mst.stop();
    endtask
    // bounded wait for channel 8 switch to reach lvl from the other level
    task automatic edge_at(input logic lvl, output time t);
        int k = 0;
        while (sw[7] === lvl && k < 40000) begin
            @(posedge clk);
            k++;
        end
        while (sw[7] !== lvl && k < 40000) begin
            @(posedge clk);
            k++;
        end
        t = $time;
    endtask
    task automatic conclude();
        $display("checks=%0d failures=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #900000;
        n_fail++;
        conclude();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rstn = 1'b0;
        en = 1'b0;
        oh = 1'b0;
        od = 8'h00;
        sd = 8'h00;
        sel = 4'hf;
        repeat (12) @(posedge clk);
        #1;
        rstn = 1'b1;
        u_mst.tick(10);
        chk_v({shut, alert_oe, sw}, 16'h0200);
        wr(8'h5e, 8'h00, 8'h03, 1'b1);
        rd(8'h5f, 3);
        chk_v(rb[0], 8'h00);
        chk_v({rb[1], rb[2]}, 16'hffff);
        en = 1'b1;
        u_mst.tick(10);
        chk_v({sw, 6'h00, sth}, 16'h0000);
        chk_v(oth, 16'hffff);
        rd(8'h5f, 1);
        chk_v(rb[0], 8'hff);
        foreach (rows[i]) begin
            wr(rows[i].adr, rows[i].d0, rows[i].d1, 1'b1);
            chk_v(sw, rows[i].sw);
            chk_v(oth, rows[i].oth);
            chk_v(sth, rows[i].sth);
        end
        sel = 4'ha;
        u_mst.tick(5);
        wr(8'h5e, 8'h00, 8'h00, 1'b0);
        wr(8'h54, 8'hff, 8'h00, 1'b1);
        od = 8'h01;
        u_mst.tick(10);
        chk_v({alert_oe, sw}, 9'h101);
        chk_v({sda_o, alert_o}, 2'h0);
        rd(8'h19, 1);
        chk_v(rb[0], 8'h54);
        chk_v(alert_oe, 1'b0);
        rd(8'h55, 2);
        chk_v(rb[1], 8'h01);
        od = 8'h00;
        sd = 8'h02;
        u_mst.tick(10);
        chk_v({alert_oe, sw}, 9'h101);
        sd = 8'h00;
        wr(8'h54, 8'hff, 8'h80, 1'b1);
        chk_v({alert_oe, sw}, 9'h000);
        oh = 1'b1;
        u_mst.tick(10);
        chk_v(alert_oe, 1'b1);
        rd(8'h55, 4);
        chk_v(rb[3][7], 1'b1);
        oh = 1'b0;
        // second shutdown with the alert still set, then a rise that must discard the write
        en = 1'b0;
        u_mst.tick(10);
        chk_v({shut, alert_oe, sw}, 16'h0200);
        wr(8'h54, 8'h0f, 8'h03, 1'b1);
        en = 1'b1;
        u_mst.tick(10);
        chk_v({alert_oe, sw, sth}, 16'h0000);
        rd(8'h55, 1);
        chk_v(rb[0], 8'hff);
        wr(8'hb4, 8'hf6, 8'h80, 1'b1);
        edge_at(1'b1, t0);
        edge_at(1'b0, t1);
        edge_at(1'b1, t2);
        chk_t(t2 - t0, 163840);
        chk_t(t2 - t1, 81920);
        conclude();
    end
endmodule

/* core/mld_core.v */
// matrix led dimmer control: serial slave, channel pwm with fade, fault flags, alert
// assumes open-drain pins resolved outside, fault comparators and switches analog
`timescale 1ns/1ns
`include "mld_map.vh"

module mld_core #(
    parameter VARIANT_ONE = 0
) (
    input wire clk,
    input wire rstn,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    output wire alert_out,
    output wire alert_oe,
    input wire [3:0] addr_sel_in,
    input wire enable_undervoltage_in,
    input wire pwm_clock_pin,
    input wire [7:0] open_detect_in,
    input wire [7:0] short_detect_in,
    input wire overheat_in,
    output wire [7:0] switch_on,
    output wire [15:0] open_threshold_sel,
    output wire [1:0] short_threshold_sel,
    output wire shutdown_out
);

// ****************************************
// input synchronisers
// ****************************************
localparam [4:0] ST_IDLE = 5'h01;
localparam [4:0] ST_RX = 5'h02;
localparam [4:0] ST_ACK = 5'h04;
localparam [4:0] ST_TX = 5'h08;
localparam [4:0] ST_RACK = 5'h10;
localparam [1:0] K_ALL = 2'h0;
localparam [1:0] K_ONE = 2'h1;
localparam [1:0] K_ARA = 2'h2;
reg [24:0] sync1_q;
reg [24:0] sync2_q;
reg [3:0] prev_q;
always @(posedge clk) begin
    if (!rstn) begin
        sync1_q <= `MLD_SYNC_RST;
        sync2_q <= `MLD_SYNC_RST;
        prev_q <= 4'hc;
    end else begin
        sync1_q <= {scl_in, sda_in, enable_undervoltage_in, pwm_clock_pin, addr_sel_in,
                    open_detect_in, short_detect_in, overheat_in};
        sync2_q <= sync1_q;
        prev_q <= sync2_q[24:21];
    end
end
wire scl_s = sync2_q[24];
wire sda_s = sync2_q[23];
wire en_s = sync2_q[22];
wire rt_s = sync2_q[21];
wire [3:0] sel_s = sync2_q[20:17];
wire [7:0] open_s = sync2_q[16:9];
wire [7:0] short_s = sync2_q[8:1];
wire ot_s = sync2_q[0];
wire scl_p = prev_q[3];
wire sda_p = prev_q[2];
wire shutdown = ~en_s;
// a rising enable is treated like reset, except by the synchronisers and the dimming time base
wire init = !rstn || (en_s && !prev_q[1]);
wire scl_rise = scl_s & ~scl_p;
wire scl_fall = ~scl_s & scl_p;
wire i2c_start = scl_s & scl_p & sda_p & ~sda_s;
wire i2c_stop = scl_s & scl_p & ~sda_p & sda_s;

// ****************************************
// serial slave
// ****************************************
reg [4:0] state_q;
reg [2:0] bit_q;
reg [3:0] idx_q;
reg [7:0] shift_q;
reg [7:0] tx_q;
reg [1:0] kind_q;
reg rw_q, first_q, full_q, sda_oe_q, alert_q;
reg [7:0] acm_q;
reg [1:0] sth_q;
reg [7:0] ctl_a_q;
reg [15:0] mode_q;
reg [15:0] oth_q;
reg [63:0] dim_q;
reg [7:0] src_ac_q;
reg [7:0] open_f_q, short_f_q;
reg ot_f_q;
// the serial port is gated by enable only for the alert response address; only the rise reloads defaults
wire [6:0] own_all = {`MLD_ADDR_ALL, sel_s};
wire [6:0] own_one = {`MLD_ADDR_ONE, sel_s};
wire hit_all = shift_q[7:1] == own_all;
wire hit_one = shift_q[7:1] == own_one;
wire hit_ara = (shift_q[7:1] == `MLD_ADDR_ARA) && shift_q[0] && alert_q && en_s;
wire rx_done = scl_fall && state_q == ST_RX && full_q;
wire wr_stb = rx_done && !first_q && !rw_q;
wire ara_done = scl_fall && state_q == ST_TX && bit_q == 3'h7 && kind_q == K_ARA;
wire [7:0] open_view = shutdown ? 8'hff : open_f_q;
wire [7:0] short_view = shutdown ? 8'hff : short_f_q;
wire ot_view = shutdown | ot_f_q;
reg [7:0] rd_byte;
always @* begin
    rd_byte = 8'h00;
    if (kind_q == K_ARA) begin
        rd_byte = {own_all, 1'b0};
    end else if (kind_q == K_ONE) begin
        if (idx_q[0])
            rd_byte = dim_q[8*idx_q[3:1] +: 8];
        else
            rd_byte = {idx_q[3:1], mode_q[2*idx_q[3:1] +: 2], oth_q[2*idx_q[3:1] +: 2], 1'b0};
    end else if (idx_q[1:0] == 2'h0) begin
        rd_byte = acm_q;
    end else if (idx_q[1:0] == 2'h1) begin
        rd_byte = open_view;
    end else if (idx_q[1:0] == 2'h2) begin
        rd_byte = short_view;
    end else begin
        rd_byte = {ot_view, 5'h00, sth_q};
    end
end
always @(posedge clk) begin
    if (init) begin
        state_q <= ST_IDLE;
        bit_q <= 3'h0;
        idx_q <= 4'h0;
        shift_q <= 8'h00;
        tx_q <= 8'h00;
        kind_q <= K_ALL;
        rw_q <= 1'b0;
        first_q <= 1'b0;
        full_q <= 1'b0;
        sda_oe_q <= 1'b0;
    end else if (i2c_start) begin
        state_q <= ST_RX;
        bit_q <= 3'h0;
        idx_q <= 4'h0;
        first_q <= 1'b1;
        full_q <= 1'b0;
        sda_oe_q <= 1'b0;
    end else if (i2c_stop) begin
        state_q <= ST_IDLE;
        sda_oe_q <= 1'b0;
    end else begin
        case (state_q)
            ST_RX: begin
                if (scl_rise) begin
                    shift_q <= {shift_q[6:0], sda_s};
                    bit_q <= bit_q + 3'h1;
                    full_q <= bit_q == 3'h7;
                end else if (rx_done) begin
                    full_q <= 1'b0;
                    if (first_q) begin
                        first_q <= 1'b0;
                        rw_q <= shift_q[0];
                        kind_q <= hit_ara ? K_ARA : (hit_one ? K_ONE : K_ALL);
                        if (hit_all || hit_one || hit_ara) begin
                            state_q <= ST_ACK;
                            sda_oe_q <= 1'b1;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end else begin
                        idx_q <= idx_q + 4'h1;
                        state_q <= ST_ACK;
                        sda_oe_q <= 1'b1;
                    end
                end
            end
            ST_ACK: begin
                if (scl_fall) begin
                    if (rw_q) begin
                        state_q <= ST_TX;
                        tx_q <= {rd_byte[6:0], 1'b0};
                        sda_oe_q <= ~rd_byte[7];
                        idx_q <= idx_q + 4'h1;
                    end else begin
                        state_q <= ST_RX;
                        sda_oe_q <= 1'b0;
                    end
                end
            end
            ST_TX: begin
                // another device on the alert response read may win arbitration
                if (scl_rise && !sda_oe_q && !sda_s) begin
                    state_q <= ST_IDLE;
                end else if (scl_fall) begin
                    bit_q <= bit_q + 3'h1;
                    if (bit_q == 3'h7) begin
                        state_q <= ST_RACK;
                        sda_oe_q <= 1'b0;
                    end else begin
                        tx_q <= {tx_q[6:0], 1'b0};
                        sda_oe_q <= ~tx_q[7];
                    end
                end
            end
            ST_RACK: begin
                if (scl_rise) begin
                    full_q <= ~sda_s;
                end else if (scl_fall) begin
                    if (full_q) begin
                        state_q <= ST_TX;
                        tx_q <= {rd_byte[6:0], 1'b0};
                        sda_oe_q <= ~rd_byte[7];
                        idx_q <= idx_q + 4'h1;
                        full_q <= 1'b0;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
            end
            default: begin
                state_q <= ST_IDLE;
                sda_oe_q <= 1'b0;
            end
        endcase
    end
end

// ****************************************
// command registers and fault flags
// ****************************************
wire wr_all = wr_stb && kind_q == K_ALL;
wire wr_one = wr_stb && kind_q == K_ONE;
wire [2:0] wr_ch = ctl_a_q[7:5];
wire clr_all = wr_all && idx_q == 4'h1 && shift_q[`MLD_CLR_ALL_BIT];
wire clr_one = wr_one && idx_q[0] && ctl_a_q[0];
wire [7:0] clr_ch = clr_all ? 8'hff : (clr_one ? (8'h01 << wr_ch) : 8'h00);
// comparators only count while enabled, a set beats a clear in the same cycle
wire [7:0] open_set = open_s & {8{en_s}};
wire [7:0] short_set = short_s & {8{en_s}};
wire ot_set = ot_s & en_s;
wire fault_new = |(open_set & ~open_f_q) | |(short_set & ~short_f_q) | (ot_set & ~ot_f_q);
always @(posedge clk) begin
    if (init) begin
        acm_q <= VARIANT_ONE ? `MLD_ACM_RST1 : `MLD_ACM_RST0;
        oth_q <= {8{VARIANT_ONE ? `MLD_OTH_RST1 : `MLD_OTH_RST0}};
        sth_q <= `MLD_STH_RST;
        ctl_a_q <= 8'h00;
        mode_q <= 16'h0000;
        dim_q <= 64'h0;
        src_ac_q <= 8'hff;
        open_f_q <= 8'h00;
        short_f_q <= 8'h00;
        ot_f_q <= 1'b0;
        alert_q <= 1'b0;
    end else begin
        if (wr_all && idx_q == 4'h0) begin
            acm_q <= shift_q;
            src_ac_q <= 8'hff;
        end
        if (wr_all && idx_q == 4'h1)
            sth_q <= shift_q[1:0];
        if (wr_one && !idx_q[0])
            ctl_a_q <= shift_q;
        if (wr_one && idx_q[0]) begin
            mode_q[2*wr_ch +: 2] <= ctl_a_q[4:3];
            oth_q[2*wr_ch +: 2] <= ctl_a_q[2:1];
            dim_q[8*wr_ch +: 8] <= shift_q;
            src_ac_q[wr_ch] <= 1'b0;
        end
        open_f_q <= (open_f_q & ~clr_ch) | open_set;
        short_f_q <= (short_f_q & ~clr_ch) | short_set;
        ot_f_q <= (ot_f_q & ~clr_all) | ot_set;
        if (fault_new)
            alert_q <= 1'b1;
        else if (ara_done || clr_all || clr_one || shutdown)
            alert_q <= 1'b0;
    end
end

// ****************************************
// dimming time base
// ****************************************
reg [7:0] osc_q;
reg [12:0] ext_q;
wire rt_rise = rt_s & ~prev_q[0];
wire ext_act = ext_q < `MLD_EXT_TIMEOUT;
// stand-in for the resistor-set oscillator; the pin wins once it toggles
wire tick = ext_act ? rt_rise : (osc_q == `MLD_OSC_DIV);
always @(posedge clk) begin
    if (!rstn) begin
        osc_q <= 8'h00;
        ext_q <= `MLD_EXT_TIMEOUT;
    end else begin
        osc_q <= (osc_q == `MLD_OSC_DIV) ? 8'h00 : osc_q + 8'h01;
        if (rt_rise)
            ext_q <= 13'h0000;
        else if (ext_act)
            ext_q <= ext_q + 13'h0001;
    end
end

// ****************************************
// per-channel pwm and fade
// ****************************************
wire [7:0] sw_d;
genvar gi;
generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_ch
        reg [10:0] cnt_q;
        reg [10:0] cur_q;
        reg [1:0] step_q;
        reg led_q;
        localparam [10:0] CNT_START = gi * 256;
        wire [1:0] mode = mode_q[2*gi +: 2];
        wire [10:0] tgt = {dim_q[8*gi +: 8], 3'h0};
        wire wrap = cnt_q == `MLD_PWM_PERIOD;
        wire [11:0] up = {1'b0, cur_q} + {5'h00, cur_q[10:4]} + 12'h001;
        wire [11:0] dn = {1'b0, cur_q} - {5'h00, cur_q[10:4]} - 12'h001;
        reg [10:0] nxt;
        always @* begin
            nxt = cur_q;
            if (mode != `MLD_MODE_FADE || step_q != `MLD_STEP_CYCLES)
                nxt = (mode == `MLD_MODE_FADE) ? cur_q : tgt;
            else if (cur_q < tgt)
                nxt = (up[11] || up[10:0] >= tgt) ? tgt : up[10:0];
            else if (cur_q > tgt)
                nxt = (dn[11] || dn[10:0] <= tgt) ? tgt : dn[10:0];
        end
        always @(posedge clk) begin
            if (init) begin
                // one-eighth cycle offset keeps channels from switching together
                cnt_q <= CNT_START;
                cur_q <= 11'h000;
                step_q <= 2'h0;
                led_q <= 1'b0;
            end else if (tick && !open_f_q[gi]) begin
                cnt_q <= cnt_q + 11'h001;
                if (wrap) begin
                    cur_q <= nxt;
                    step_q <= step_q + 2'h1;
                    led_q <= nxt != 11'h000;
                end else if (cnt_q + 11'h001 == cur_q) begin
                    led_q <= 1'b0;
                end
            end
        end
        assign sw_d[gi] = shutdown ? 1'b0 :
            open_f_q[gi] ? 1'b1 :
            src_ac_q[gi] ? ~acm_q[gi] :
            (mode == `MLD_MODE_PWM || mode == `MLD_MODE_FADE) ? ~led_q : (mode == `MLD_MODE_BYPASS);
    end
endgenerate

reg [7:0] sw_q;
always @(posedge clk) begin
    if (init) // stale shutdown writes must not flash the switches
        sw_q <= 8'h00;
    else
        sw_q <= sw_d;
end

// ****************************************
// outputs
// ****************************************
assign sda_out = 1'b0;
assign sda_oe = sda_oe_q;
assign alert_out = 1'b0;
assign alert_oe = alert_q & en_s;
assign switch_on = sw_q;
assign open_threshold_sel = oth_q;
assign short_threshold_sel = sth_q;
assign shutdown_out = shutdown;

endmodule

/* inc/mld_map.vh */
// constants of the matrix led dimmer control logic
// assumes one 100 MHz clock and plain verilog includes by bare name
`ifndef MLD_MAP_VH
`define MLD_MAP_VH

// ****************************************
// serial addressing
// ****************************************
`define MLD_ADDR_ALL 3'h2
`define MLD_ADDR_ONE 3'h5
`define MLD_ADDR_ARA 7'h0c

// ****************************************
// channel modes and defaults
// ****************************************
`define MLD_MODE_BYPASS 2'h0
`define MLD_MODE_LEDON 2'h1
`define MLD_MODE_PWM 2'h2
`define MLD_MODE_FADE 2'h3
`define MLD_ACM_RST0 8'hff
`define MLD_ACM_RST1 8'h00
`define MLD_OTH_RST0 2'h3
`define MLD_OTH_RST1 2'h1
`define MLD_STH_RST 2'h0
`define MLD_CLR_ALL_BIT 7

// ****************************************
// timing
// ****************************************
`define MLD_PWM_PERIOD 11'h7ff
`define MLD_STEP_CYCLES 2'h3
`define MLD_FADE_SHIFT 4
`define MLD_OSC_DIV 8'h31
`define MLD_EXT_TIMEOUT 13'h1000
`define MLD_SYNC_RST 25'h1800000

`endif
